// ---- dpc_pkg.sv ----
// constants, field positions and carrier types for the dual port controller
// assumes a single 50 MHz clock and a bus of active-low processor control pins
package dpc_pkg;
   localparam int DPC_DW = 8;
   localparam int DPC_PORT_A = 0;
   localparam int DPC_PORT_B = 1;
   // mode codes
   localparam logic [1:0] DPC_MODE_OUT = 2'h0;
   localparam logic [1:0] DPC_MODE_IN = 2'h1;
   localparam logic [1:0] DPC_MODE_BIDIR = 2'h2;
   localparam logic [1:0] DPC_MODE_BIT = 2'h3;
   // control word tags and fields
   localparam logic [3:0] DPC_CW_MODE_TAG = 4'hf;
   localparam logic [3:0] DPC_CW_INTCTL_TAG = 4'h7;
   localparam logic [3:0] DPC_CW_INTEN_TAG = 4'h3;
   localparam int DPC_CW_MODE_HI = 7;
   localparam int DPC_CW_MODE_LO = 6;
   localparam int DPC_CW_FUNC_BIT = 7;
   localparam int DPC_CW_IEN_BIT = 6;
   localparam int DPC_CW_LEVEL_BIT = 5;
   localparam int DPC_CW_MASKNEXT_BIT = 4;
   localparam int DPC_CW_ENONLY_BIT = 7;
   localparam int DPC_VEC_FLAG_BIT = 0;
   // return-from-interrupt opcode pair
   localparam logic [7:0] DPC_RETURN_FROM_INTERRUPT_OPCODE_PREFIX = 8'hed;
   localparam logic [7:0] DPC_RETURN_FROM_INTERRUPT_OPCODE_CODE = 8'h4d;
   // reset values
   localparam logic [1:0] DPC_MODE_RST = DPC_MODE_IN;
   localparam logic [7:0] DPC_DIR_RST = 8'h00;
   localparam logic [7:0] DPC_MASK_RST = 8'hff;
   localparam logic [7:0] DPC_VEC_RST = 8'h00;
   localparam logic [7:0] DPC_BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      DPC_IS_IDLE = 2'b01,
      DPC_IS_SERV = 2'b10
   } dpc_isr_t;

   typedef struct packed {
      logic chip_enable_n;
      logic io_request_n;
      logic read_n;
      logic machine_cycle_n;
      logic port_b_select;
      logic control_select;
      logic [7:0] data;
   } dpc_bus_t;

   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } dpc_pins_t;
endpackage

// ---- dpc_sync2.sv ----
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no multi-bit coherence
`timescale 1ns/1ps
module dpc_sync2 #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // ==================================================================
   // stages
   // the first stage only feeds the second; reset value is all ones,
   // which is the idle level of every active-low input here
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule // dpc_sync2

// ---- dpc_top.sv ----
// dual 8-bit parallel port controller with daisy-chained interrupts
// assumes processor pins and peripheral pins are asynchronous to clock
`timescale 1ns/1ps
module dpc_top (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // processor bus
   input wire dpc_pkg::dpc_bus_t bus_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic int_out,
   output logic int_oe,
   // priority chain
   input wire logic chain_enable_in,
   output logic chain_enable_out,
   // port A
   input wire logic [7:0] port_a_in,
   output dpc_pkg::dpc_pins_t port_a_pins,
   input wire logic port_a_strobe_in_n,
   output logic port_a_ready_out,
   // port B
   input wire logic [7:0] port_b_in,
   output dpc_pkg::dpc_pins_t port_b_pins,
   input wire logic port_b_strobe_in_n,
   output logic port_b_ready_out
);
   import dpc_pkg::*;

   localparam int SW = $bits(dpc_bus_t) + 2 + 2 * DPC_DW + 1;

   // synchronised inputs
   logic [SW-1:0] sync_v;
   dpc_bus_t s;
   logic [1:0] stb_s;
   logic [7:0] pin_s [2];
   logic chain_s;

   // per-port state
   logic [1:0] mode_q [2], mode_d [2];
   logic [7:0] dir_q [2], dir_d [2];
   logic [7:0] mask_q [2], mask_d [2];
   logic [7:0] vec_q [2], vec_d [2];
   logic [7:0] out_q [2], out_d [2];
   logic [7:0] in_q [2], in_d [2];
   logic [1:0] func_and_q, func_and_d, lvl_high_q, lvl_high_d, ien_q, ien_d;
   logic [1:0] want_dir_q, want_dir_d, want_mask_q, want_mask_d;
   logic [1:0] out_full_q, out_full_d, in_full_q, in_full_d;
   logic [1:0] pend_q, pend_d, match_prev_q, match_prev_d, stb_prev_q, stb_prev_d;
   dpc_isr_t isr_q [2], isr_d [2];

   // bus-side state
   logic armed_q, armed_d, wr_prev_q, wr_prev_d, rd_prev_q, rd_prev_d;
   logic rd_port_q, rd_port_d, rd_ctrl_q, rd_ctrl_d;
   logic ack_prev_q, ack_prev_d, fetch_prev_q, fetch_prev_d;
   logic prefix_q, prefix_d, m1_prev_q, m1_prev_d, seen_q, seen_d;
   logic soft_rst_q, soft_rst_d, int_oe_q, int_oe_d, bus_oe_q, bus_oe_d;
   logic [7:0] op_q, op_d, data_out_q, data_out_d;

   // decoded strobes
   logic wr_act, rd_act, ack_act, fetch_act, m1_low;
   logic wr_pulse, rd_end, ack_rise, fetch_end, return_from_interrupt_opcode_hit, a_bidir;
   logic [1:0] serv, stb_low, stb_rise, match, ev, int_ok;

   // ==================================================================
   // input synchronisers
   dpc_sync2 #(.W(SW)) u_sync (
      .clock(clock),
      .srst(srst),
      .async_in({bus_in, port_a_strobe_in_n, port_b_strobe_in_n, port_a_in, port_b_in,
                 chain_enable_in}),
      .sync_out(sync_v)
   );

   assign s = dpc_bus_t'(sync_v[SW-1 -: $bits(dpc_bus_t)]);
   // port A strobe sits one bit above port B in the bundle; index by port number
   assign stb_s = ~{sync_v[2*DPC_DW+1], sync_v[2*DPC_DW+2]};
   assign pin_s[DPC_PORT_A] = sync_v[2*DPC_DW -: DPC_DW];
   assign pin_s[DPC_PORT_B] = sync_v[DPC_DW -: DPC_DW];
   assign chain_s = sync_v[0];

   // ==================================================================
   // bus cycle decode
   // stb_s is active high after the inversion above
   assign wr_act = !s.chip_enable_n && !s.io_request_n && s.read_n
                   && s.machine_cycle_n;
   assign rd_act = !s.chip_enable_n && !s.io_request_n && !s.read_n;
   assign ack_act = !s.io_request_n && !s.machine_cycle_n;
   assign fetch_act = !s.machine_cycle_n && !s.read_n;
   assign m1_low = !s.machine_cycle_n;
   assign wr_pulse = wr_act && !wr_prev_q;
   assign rd_end = !rd_act && rd_prev_q;
   assign ack_rise = ack_act && !ack_prev_q;
   assign fetch_end = !fetch_act && fetch_prev_q;
   assign return_from_interrupt_opcode_hit = fetch_end && prefix_q && (op_q == DPC_RETURN_FROM_INTERRUPT_OPCODE_CODE);
   assign a_bidir = (mode_q[DPC_PORT_A] == DPC_MODE_BIDIR);

   // match on active level, OR of any or AND of all unmasked lines
   function automatic logic level_match(input logic [7:0] pins, input logic [7:0] msk,
                                        input logic hi, input logic and_f);
      logic [7:0] act;
      act = hi ? pins : ~pins;
      if (and_f)
         level_match = (&(act | msk)) && (|(~msk));
      else
         level_match = |(act & ~msk);
   endfunction

   // ==================================================================
   // derived per-port levels
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         serv[p] = (isr_q[p] == DPC_IS_SERV);
         stb_low[p] = stb_s[p] && (mode_q[p] != DPC_MODE_BIT);
         stb_rise[p] = !stb_s[p] && stb_prev_q[p] && (mode_q[p] != DPC_MODE_BIT);
         match[p] = level_match(pin_s[p], mask_q[p], lvl_high_q[p], func_and_q[p]);
      end
      // port A request outranks port B and a serviced A blocks B
      int_ok[DPC_PORT_A] = pend_q[DPC_PORT_A] && !serv[DPC_PORT_A];
      int_ok[DPC_PORT_B] = pend_q[DPC_PORT_B] && !serv[DPC_PORT_A] && !serv[DPC_PORT_B];
   end

   // ==================================================================
   // next-state logic for ports, interrupts and bus answers
   always_comb begin
      logic sel;
      logic [7:0] w;
      int win;
      sel = 1'b0;
      w = s.data;
      win = DPC_PORT_B;
      mode_d = mode_q; dir_d = dir_q; mask_d = mask_q; vec_d = vec_q;
      out_d = out_q; in_d = in_q; isr_d = isr_q;
      func_and_d = func_and_q; lvl_high_d = lvl_high_q; ien_d = ien_q;
      want_dir_d = want_dir_q; want_mask_d = want_mask_q;
      out_full_d = out_full_q; in_full_d = in_full_q; pend_d = pend_q;
      match_prev_d = match; stb_prev_d = stb_s;
      ev = 2'b00;
      armed_d = armed_q || m1_low;
      wr_prev_d = wr_act; rd_prev_d = rd_act; ack_prev_d = ack_act;
      fetch_prev_d = fetch_act; m1_prev_d = m1_low;
      rd_port_d = rd_act ? s.port_b_select : rd_port_q;
      rd_ctrl_d = rd_act ? s.control_select : rd_ctrl_q;
      op_d = fetch_act ? s.data : op_q;
      prefix_d = fetch_end ? (op_q == DPC_RETURN_FROM_INTERRUPT_OPCODE_PREFIX) : prefix_q;
      // reset when machine cycle ends without read or io request seen
      seen_d = m1_low ? (seen_q || !s.read_n || !s.io_request_n) : 1'b0;
      soft_rst_d = m1_prev_q && !m1_low && !seen_q;
      data_out_d = data_out_q;
      bus_oe_d = rd_act || (ack_act && bus_oe_q);

      for (int p = 0; p < 2; p++) begin
         sel = (s.port_b_select == 1'(p));
         // processor read ends: input register counts as empty again
         if (rd_end && rd_port_q == 1'(p) && !rd_ctrl_q)
            in_full_d[p] = 1'b0;
         // peripheral handshake by mode
         case (mode_q[p])
            DPC_MODE_OUT: begin
               if (stb_rise[p]) begin
                  out_full_d[p] = 1'b0;
                  ev[p] = 1'b1;
               end
            end
            DPC_MODE_IN: begin
               if (stb_low[p] && !in_full_q[p])
                  in_d[p] = pin_s[p];
               if (stb_rise[p]) begin
                  in_full_d[p] = 1'b1;
                  ev[p] = 1'b1;
               end
            end
            DPC_MODE_BIDIR: begin
               // port A strobe acks output, port B strobe loads input
               if (p == DPC_PORT_A && stb_rise[DPC_PORT_A]) begin
                  out_full_d[p] = 1'b0;
                  ev[DPC_PORT_A] = 1'b1;
               end
               if (p == DPC_PORT_A && stb_s[DPC_PORT_B] && !in_full_q[p])
                  in_d[p] = pin_s[p];
               if (p == DPC_PORT_A && !stb_s[DPC_PORT_B] && stb_prev_q[DPC_PORT_B]) begin
                  in_full_d[p] = 1'b1;
                  ev[DPC_PORT_B] = 1'b1;
               end
            end
            DPC_MODE_BIT: begin
               // input register freezes while a read is in progress
               if (!rd_act)
                  in_d[p] = pin_s[p];
               // port B is not polled while A runs bidirectional
               if (!(p == DPC_PORT_B && a_bidir) && match[p] && !match_prev_q[p])
                  ev[p] = 1'b1;
            end
            default: begin
               in_d[p] = in_q[p];
            end
         endcase
         // control words
         if (wr_pulse && sel && s.control_select) begin
            if (want_dir_q[p]) begin
               dir_d[p] = w;
               want_dir_d[p] = 1'b0;
            end else if (want_mask_q[p]) begin
               mask_d[p] = w;
               want_mask_d[p] = 1'b0;
            end else if (w[3:0] == DPC_CW_MODE_TAG) begin
               mode_d[p] = w[DPC_CW_MODE_HI:DPC_CW_MODE_LO];
               want_dir_d[p] = (w[DPC_CW_MODE_HI:DPC_CW_MODE_LO] == DPC_MODE_BIT);
               out_full_d[p] = 1'b0;
               in_full_d[p] = 1'b0;
            end else if (!w[DPC_VEC_FLAG_BIT]) begin
               vec_d[p] = w;
            end else if (w[3:0] == DPC_CW_INTCTL_TAG) begin
               func_and_d[p] = w[DPC_CW_FUNC_BIT];
               lvl_high_d[p] = w[DPC_CW_LEVEL_BIT];
               want_mask_d[p] = w[DPC_CW_MASKNEXT_BIT];
               ien_d[p] = w[DPC_CW_IEN_BIT];
               armed_d = 1'b0;
            end else if (w[3:0] == DPC_CW_INTEN_TAG) begin
               ien_d[p] = w[DPC_CW_ENONLY_BIT];
               armed_d = 1'b0;
            end
         end
         // data write after the handshake so a load beats a same-cycle ack
         if (wr_pulse && sel && !s.control_select) begin
            out_d[p] = w;
            if (mode_q[p] != DPC_MODE_BIT)
               out_full_d[p] = 1'b1;
         end
      end

      // return-from-interrupt ends the highest service level first
      if (return_from_interrupt_opcode_hit) begin
         if (serv[DPC_PORT_A])
            isr_d[DPC_PORT_A] = DPC_IS_IDLE;
         else
            isr_d[DPC_PORT_B] = DPC_IS_IDLE;
      end
      // acknowledge: highest pending port drives its vector
      if (ack_rise && chain_s && |int_ok) begin
         win = int_ok[DPC_PORT_A] ? DPC_PORT_A : DPC_PORT_B;
         pend_d[win] = 1'b0;
         isr_d[win] = DPC_IS_SERV;
         data_out_d = {vec_q[win][7:1], 1'b0};
         bus_oe_d = 1'b1;
      end else if (rd_act) begin
         data_out_d = DPC_BYTE_RST;
         for (int p = 0; p < 2; p++) begin
            if (s.port_b_select == 1'(p) && !s.control_select) begin
               if (mode_q[p] == DPC_MODE_BIT)
                  data_out_d = (out_q[p] & dir_q[p]) | (in_q[p] & ~dir_q[p]);
               else if (mode_q[p] == DPC_MODE_OUT)
                  data_out_d = out_q[p];
               else
                  data_out_d = in_q[p];
            end
         end
      end
      // a new event sets pending after any acknowledge clear
      for (int p = 0; p < 2; p++) begin
         if (ev[p] && ien_q[p])
            pend_d[p] = 1'b1;
      end
      int_oe_d = armed_q && chain_s && |int_ok;
   end

   // ==================================================================
   // state registers
   always_ff @(posedge clock) begin
      if (srst || soft_rst_q) begin
         for (int p = 0; p < 2; p++) begin
            mode_q[p] <= DPC_MODE_RST;
            dir_q[p] <= DPC_DIR_RST;
            mask_q[p] <= DPC_MASK_RST;
            vec_q[p] <= DPC_VEC_RST;
            out_q[p] <= DPC_BYTE_RST;
            in_q[p] <= DPC_BYTE_RST;
            isr_q[p] <= DPC_IS_IDLE;
         end
         func_and_q <= '0; lvl_high_q <= '0; ien_q <= '0;
         want_dir_q <= '0; want_mask_q <= '0;
         out_full_q <= '0; in_full_q <= '0; pend_q <= '0;
         match_prev_q <= '0; stb_prev_q <= '0;
         armed_q <= 1'b0; wr_prev_q <= 1'b0; rd_prev_q <= 1'b0;
         rd_port_q <= 1'b0; rd_ctrl_q <= 1'b0; ack_prev_q <= 1'b0;
         fetch_prev_q <= 1'b0; prefix_q <= 1'b0; m1_prev_q <= 1'b0;
         seen_q <= 1'b0; soft_rst_q <= 1'b0; int_oe_q <= 1'b0; bus_oe_q <= 1'b0;
         op_q <= DPC_BYTE_RST; data_out_q <= DPC_BYTE_RST;
      end else begin
         mode_q <= mode_d; dir_q <= dir_d; mask_q <= mask_d; vec_q <= vec_d;
         out_q <= out_d; in_q <= in_d; isr_q <= isr_d;
         func_and_q <= func_and_d; lvl_high_q <= lvl_high_d; ien_q <= ien_d;
         want_dir_q <= want_dir_d; want_mask_q <= want_mask_d;
         out_full_q <= out_full_d; in_full_q <= in_full_d; pend_q <= pend_d;
         match_prev_q <= match_prev_d; stb_prev_q <= stb_prev_d;
         armed_q <= armed_d; wr_prev_q <= wr_prev_d; rd_prev_q <= rd_prev_d;
         rd_port_q <= rd_port_d; rd_ctrl_q <= rd_ctrl_d; ack_prev_q <= ack_prev_d;
         fetch_prev_q <= fetch_prev_d; prefix_q <= prefix_d; m1_prev_q <= m1_prev_d;
         seen_q <= seen_d; soft_rst_q <= soft_rst_d; int_oe_q <= int_oe_d;
         bus_oe_q <= bus_oe_d; op_q <= op_d; data_out_q <= data_out_d;
      end
   end

   // ==================================================================
   // outputs
   // ready by mode; port B follows port A's input side in bidir
   always_comb begin
      case (mode_q[DPC_PORT_A])
         DPC_MODE_OUT: port_a_ready_out = out_full_q[DPC_PORT_A];
         DPC_MODE_IN: port_a_ready_out = !in_full_q[DPC_PORT_A];
         DPC_MODE_BIDIR: port_a_ready_out = out_full_q[DPC_PORT_A];
         default: port_a_ready_out = 1'b0;
      endcase
      if (a_bidir)
         port_b_ready_out = !in_full_q[DPC_PORT_A];
      else if (mode_q[DPC_PORT_B] == DPC_MODE_OUT)
         port_b_ready_out = out_full_q[DPC_PORT_B];
      else if (mode_q[DPC_PORT_B] == DPC_MODE_IN)
         port_b_ready_out = !in_full_q[DPC_PORT_B];
      else
         port_b_ready_out = 1'b0;
   end

   // pin drivers; bidir drives A only while its strobe is low
   always_comb begin
      port_a_pins.dout = out_q[DPC_PORT_A];
      port_b_pins.dout = out_q[DPC_PORT_B];
      case (mode_q[DPC_PORT_A])
         DPC_MODE_OUT: port_a_pins.oe = '1;
         DPC_MODE_BIDIR: port_a_pins.oe = {DPC_DW{stb_s[DPC_PORT_A]}};
         DPC_MODE_BIT: port_a_pins.oe = dir_q[DPC_PORT_A];
         default: port_a_pins.oe = '0;
      endcase
      case (mode_q[DPC_PORT_B])
         DPC_MODE_OUT: port_b_pins.oe = '1;
         DPC_MODE_BIT: port_b_pins.oe = dir_q[DPC_PORT_B];
         default: port_b_pins.oe = '0;
      endcase
   end

   assign data_out = data_out_q;
   assign data_oe = bus_oe_q;
   assign int_out = 1'b0;
   assign int_oe = int_oe_q;
   assign chain_enable_out = chain_s && !(|serv);

   // ==================================================================
   // checks
   AST_BIT_READY_LOW: assert property (@(posedge clock) disable iff (srst)
      mode_q[DPC_PORT_A] == DPC_MODE_BIT |-> !port_a_ready_out)
      else $error("ready high in bit mode");
   AST_VECTOR_BIT0: assert property (@(posedge clock) disable iff (srst)
      ack_rise && chain_s && |int_ok |=> data_out_q[0] == 1'b0 && bus_oe_q)
      else $error("vector bit 0 not zero");
   AST_CHAIN_OUT: assert property (@(posedge clock) disable iff (srst)
      serv != 2'b00 |-> !chain_enable_out)
      else $error("chain out high while in service");
   AST_CHAIN_BLOCKS: assert property (@(posedge clock) disable iff (srst)
      !chain_s |=> !int_oe_q)
      else $error("request raised while chain disabled");
   AST_ARM_M1: assert property (@(posedge clock) disable iff (srst)
      $rose(armed_q) |-> $past(m1_low))
      else $error("armed without machine cycle");
   AST_A_FIRST: assert property (@(posedge clock) disable iff (srst || soft_rst_q)
      ack_rise && chain_s && int_ok[DPC_PORT_A] |=> isr_q[DPC_PORT_A] == DPC_IS_SERV
         && $stable(isr_q[DPC_PORT_B]))
      else $error("port A did not win the acknowledge");
   AST_OUT_READY: assert property (@(posedge clock) disable iff (srst || soft_rst_q)
      wr_pulse && !s.port_b_select && !s.control_select
         && mode_q[DPC_PORT_A] == DPC_MODE_OUT |=> port_a_ready_out)
      else $error("ready not raised after output load");
   AST_IN_LATCH: assert property (@(posedge clock) disable iff (srst || soft_rst_q)
      mode_q[DPC_PORT_A] == DPC_MODE_IN && stb_s[DPC_PORT_A] && !in_full_q[DPC_PORT_A]
         |=> in_q[DPC_PORT_A] == $past(pin_s[DPC_PORT_A]))
      else $error("input register missed strobe data");
   AST_SOFT_RESET: assert property (@(posedge clock) disable iff (srst)
      soft_rst_q |=> mode_q[DPC_PORT_A] == DPC_MODE_RST && pend_q == 2'b00)
      else $error("machine cycle reset did not clear state");
endmodule // dpc_top

// ---- dpc_periph.sv ----
// peripheral model driving port A lines and the active-low port A strobe
// assumes the bench calls send from its own sequence; one byte per call
`timescale 1ns/1ps
module dpc_periph (
   // clock
   input wire logic clock,
   // port side
   output logic strobe_n,
   output logic [7:0] lines
);
   // idle: strobe high, lines start at zero rather than a stale byte
   initial begin
      strobe_n = 1'b1;
      lines = 8'h00;
   end
   // data first, strobe low for three clocks, then release
   task automatic send(input logic [7:0] d);
      @(negedge clock) lines = d;
      @(negedge clock) strobe_n = 1'b0;
      repeat (3) @(negedge clock);
      strobe_n = 1'b1;
      repeat (2) @(negedge clock);
      lines = ~d; // held time over, no stale value
   endtask
endmodule // dpc_periph

// ---- test_dpc_top.sv ----
// self-checking bench for the dual port controller
// assumes bus pins pass a two-flop sync, so each access is held four clocks
`timescale 1ns/1ps
module test_dpc_top;
   import dpc_pkg::*;
   logic clock = 1'b0, srst = 1'b1, chain_in = 1'b1;
   dpc_bus_t bus = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
   logic [7:0] data_out, a_in, got, b_in = 8'h00;
   logic data_oe, int_out, int_oe, chain_out, a_stb_n, a_rdy, b_rdy;
   dpc_pins_t a_pins, b_pins;
   int error_cnt = 0, tests_run = 0;
   dpc_top dut_u (.clock(clock), .srst(srst), .bus_in(bus), .data_out(data_out),
      .data_oe(data_oe), .int_out(int_out), .int_oe(int_oe), .chain_enable_in(chain_in),
      .chain_enable_out(chain_out), .port_a_in(a_in), .port_a_pins(a_pins),
      .port_a_strobe_in_n(a_stb_n), .port_a_ready_out(a_rdy), .port_b_in(b_in),
      .port_b_pins(b_pins), .port_b_strobe_in_n(1'b1), .port_b_ready_out(b_rdy));
   dpc_periph periph_u (.clock(clock), .strobe_n(a_stb_n), .lines(a_in));
   // ==========================================================
   // clock and common tasks
   always #10 clock = ~clock;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // n = ce, io_request_n, rd, m1 (active low); data sampled before release
   task automatic acc(input logic [3:0] n, input logic sel, input logic cs, input logic [7:0] d);
      @(negedge clock) bus = '{n[3], n[2], n[1], n[0], sel, cs, d};
      repeat (4) @(negedge clock);
      got = data_oe ? data_out : 8'hxx;
      bus = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
      repeat (3) @(negedge clock);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk({a_rdy, b_rdy, data_oe, int_oe, chain_out, int_out}, 8'h32);
      chk(a_pins.oe, 8'h00);
      $display("reset values done");
   endtask
   task automatic t_out();
      acc(4'b0011, 1'b0, 1'b1, 8'h0f);
      acc(4'b0011, 1'b0, 1'b0, 8'ha5);
      chk({a_pins.dout, a_pins.oe}, 16'ha5ff);
      chk(8'(a_rdy), 8'h01);
      periph_u.send(8'h00);
      repeat (2) @(negedge clock);
      chk(8'(a_rdy), 8'h00);
      $display("output mode done");
   endtask
   task automatic t_in_int();
      acc(4'b0011, 1'b0, 1'b1, 8'h4f);
      acc(4'b0011, 1'b0, 1'b1, 8'h20);
      acc(4'b0011, 1'b0, 1'b1, 8'h47);
      chk(8'(a_rdy), 8'h01);
      acc(4'b1100, 1'b0, 1'b0, 8'h00);
      periph_u.send(8'h3c);
      repeat (3) @(negedge clock);
      chk({a_rdy, int_oe}, 8'h01);
      acc(4'b1010, 1'b0, 1'b0, 8'h00);
      chk(got, 8'h20);
      chk({chain_out, int_oe}, 8'h00);
      acc(4'b1100, 1'b0, 1'b0, 8'hed);
      acc(4'b1100, 1'b0, 1'b0, 8'h4d);
      chk(8'(chain_out), 8'h01);
      acc(4'b0001, 1'b0, 1'b0, 8'h00);
      chk(got, 8'h3c);
      chk(8'(a_rdy), 8'h01);
      $display("input mode interrupt done");
   endtask
   task automatic t_bit();
      acc(4'b0011, 1'b1, 1'b1, 8'hcf);
      acc(4'b0011, 1'b1, 1'b1, 8'h0f);
      acc(4'b0011, 1'b1, 1'b0, 8'h5a);
      chk(b_pins.oe, 8'h0f);
      chk({b_pins.dout[3:0], 3'h0, b_rdy}, 8'ha0);
      // AND of high levels on lines 7:4, lines 3:0 masked, enable given last
      acc(4'b0011, 1'b1, 1'b1, 8'h30);
      acc(4'b0011, 1'b1, 1'b1, 8'hb7);
      acc(4'b0011, 1'b1, 1'b1, 8'h0f);
      acc(4'b0011, 1'b1, 1'b1, 8'h83);
      b_in = 8'hf0;
      repeat (6) @(negedge clock);
      chk(int_oe, 1'b0);
      acc(4'b1100, 1'b0, 1'b0, 8'h00);
      chk({chain_out, int_oe}, 8'h03);
      chain_in = 1'b0;
      repeat (4) @(negedge clock);
      chk({chain_out, int_oe}, 8'h00);
      chain_in = 1'b1;
      repeat (4) @(negedge clock);
      acc(4'b1010, 1'b0, 1'b0, 8'h00);
      chk(got, 8'h30);
      acc(4'b1100, 1'b0, 1'b0, 8'hed);
      acc(4'b1100, 1'b0, 1'b0, 8'h4d);
      chk(8'(chain_out), 8'h01);
      $display("bit mode done");
   endtask
   task automatic t_bidir();
      acc(4'b0011, 1'b0, 1'b1, 8'h8f);
      chk({a_rdy, b_rdy}, 8'h01);
      acc(4'b0011, 1'b0, 1'b0, 8'h77);
      chk({a_rdy, a_pins.oe}, 16'h0100);
      periph_u.send(8'h11);
      repeat (3) @(negedge clock);
      chk({a_rdy, int_oe}, 8'h01);
      $display("bidirectional mode done");
   endtask
   task automatic t_soft();
      // machine cycle with neither read nor io request: reset lands two edges later
      acc(4'b1110, 1'b0, 1'b0, 8'h00);
      repeat (2) @(negedge clock);
      chk({a_rdy, b_rdy, int_oe, chain_out}, 8'h0d);
      chk({a_pins.oe, b_pins.oe}, 16'h0000);
      $display("machine cycle reset done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (20) @(negedge clock);
      srst = 1'b0;
      repeat (4) @(negedge clock);
      t_reset();
      t_out();
      t_in_int();
      t_bit();
      t_bidir();
      t_soft();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      summarize();
   end
endmodule // test_dpc_top
